// File: design/sbs_consts.svh
/*
  constants for the synthesizer band-select and status block and its host.
  assumes a 100 MHz aclk and 4-bit register addresses on the link.
*/
`ifndef SBS_CONSTS_SVH
`define SBS_CONSTS_SVH

`define SBS_CLK_NS       10
`define SBS_REG_INT_HI   4'h0
`define SBS_REG_INT_LO   4'h1
`define SBS_REG_FRAC_MSB 4'h3
`define SBS_REG_FRAC_LSB 4'h4
`define SBS_REG_REFDIV   4'h5
`define SBS_REG_PLL      4'h6
`define SBS_REG_VCO      4'h7
`define SBS_REG_CTRL     4'h9
`define SBS_REG_TEST     4'hB
`define SBS_REG_STAT1    4'hC
`define SBS_REG_STAT2    4'hD
`define SBS_NUM_RW       12
`define SBS_RST_PLL      8'hC0
`define SBS_RST_VCO      8'hCC
`define SBS_RST_TEST     8'h08
`define SBS_VCO_VAS      2
`define SBS_VCO_ADL      1
`define SBS_VCO_ADE      0
`define SBS_CTRL_STANDBY_BIT    7
`define SBS_TEST_RSVD    4
`define SBS_TEST_FAST    3
`define SBS_INT_HI_TOP   7
`define SBS_NUM_BANDS    24
`define SBS_LAST_BAND    5'h17
`define SBS_RST_BAND     5'h19
`define SBS_BAND_FLD     7:3
`define SBS_PUMP_FLD     7:5
`define SBS_REFSEL_FLD   2:0
`define SBS_ADC_VAS_LO   3'h2
`define SBS_ADC_VAS_HI   3'h5
`define SBS_CMD_ADDR_FLD 11:8
`define SBS_CMD_DATA_FLD 7:0
`define SBS_SETTLE_NS    2000
`define SBS_SETTLE_CYC   (`SBS_SETTLE_NS / `SBS_CLK_NS)
`define SBS_PWRUP_US     100
`define SBS_PWRUP_CYC    (`SBS_PWRUP_US * 1000 / `SBS_CLK_NS)
`define SBS_AXI_CMD      4'h0
`define SBS_AXI_STAT     4'h4
`define SBS_CMD_RD       16
`define SBS_RESP_OKAY    2'h0
`define SBS_RESP_SLVERR  2'h2

`endif

// File: design/sbs_pkg.sv
/*
  types shared by the band-select device end and its host end.
  assumes nothing beyond a SystemVerilog compiler.
*/
package sbs_pkg;
  typedef logic [3:0] sbs_addr_t;
  typedef logic [7:0] sbs_byte_t;
  typedef enum logic [1:0] {AS_IDLE, AS_SETTLE, AS_CHECK} sbs_as_e;
  typedef enum logic [1:0] {LK_IDLE, LK_REQ, LK_STOP} sbs_link_e;
endpackage : sbs_pkg

// File: design/sbs_link_if.sv
/*
  register link between the host controller and the band-select device.
  assumes both ends run on the same aclk.
*/
`timescale 1ns/1ps
interface sbs_link_if;
  logic               req;
  logic               we;
  sbs_pkg::sbs_addr_t addr;
  sbs_pkg::sbs_byte_t wdata;
  logic               stop;
  logic               ack;
  sbs_pkg::sbs_byte_t rdata;
  modport dev
  (
    input  req,
    input  we,
    input  addr,
    input  wdata,
    input  stop,
    output ack,
    output rdata
  );
  modport host
  (
    output req,
    output we,
    output addr,
    output wdata,
    output stop,
    input  ack,
    input  rdata
  );
endinterface : sbs_link_if

// File: design/sbs_device.sv
/*
  device end: register bank, status bytes, band autoselect, tune adc latch, standby.
  assumes the host holds req until ack and pulses stop after each transfer;
  lock and tune code arrive from analog pins outside the clock domain.
*/
// Behaviour
// - pump test field bits 7:5, reset 000
// - host sets fast_lock after power-up
// - ref_out_select bits 2:0, kept at 000
// - power-on flag cleared by status read plus stop
// - success set on good search, else zero
// - done low while search runs
// - lock bit valid only with fast_lock set
// - second status: band 7:3, adc 2:0
// - adc codes: out, locked, autoselect-locked
// - 24 bands, manual band reported back
// - lsb divider write starts autoselect
// - host writes register 0x4 last
// - host rewrites all dividers on retune
// - search starts from programmed band
// - done cleared at start, set at end
// - accept only autoselect-locked adc codes
// - adc enable then latch stores the code
// - standby keeps only bus and crystal running
// - registers kept across standby
// - host waits 100us then programs all
// - host encodes dividers as straight binary
// - oscillator bit 2 enables autoselect
`timescale 1ns/1ps
`include "sbs_consts.svh"
module sbs_device
#(
  parameter int SETTLE_CYC = `SBS_SETTLE_CYC
)
(
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // register link
  sbs_link_if.dev         link,
  // analog status pins
  input  wire logic       pll_lock_pin,
  input  wire logic [2:0] tune_code_pin,
  // analog controls
  output logic [4:0]      band_sel,
  output logic            synth_en,
  output logic            rf_path_en,
  output logic [2:0]      pump_test_mode,
  output logic            fast_lock,
  output logic [2:0]      ref_out_select
);
  import sbs_pkg::*;

  if (SETTLE_CYC < 1 || SETTLE_CYC > 65535)
  begin : g_bad_settle
    $error("settle count out of range");
  end

  typedef struct packed {
    logic [`SBS_NUM_RW-1:0][7:0] regs;
    logic                        por;
    logic                        stat_rd;
    sbs_as_e                     as_st;
    logic [4:0]                  band;
    logic [4:0]                  tries;
    logic [15:0]                 cnt;
    logic                        as_ok;
    logic [2:0]                  adc;
    logic [2:0]                  code_s1;
    logic [2:0]                  code_s2;
    logic [2:0]                  code_s3;
    logic [2:0]                  code_f;
    logic                        lock_s1;
    logic                        lock_s2;
    logic                        lock_s3;
    logic                        lock_f;
    logic                        ack;
    logic [7:0]                  rdata;
    logic                        synth_en;
    logic                        rf_en;
  } sbs_dev_s;

  sbs_dev_s st_r;
  sbs_dev_s st_nxt;

  function automatic logic [7:0] reset_value(input int idx);
    case (idx)
      int'(`SBS_REG_PLL):  reset_value = `SBS_RST_PLL;
      int'(`SBS_REG_VCO):  reset_value = `SBS_RST_VCO;
      int'(`SBS_REG_TEST): reset_value = `SBS_RST_TEST;
      default:             reset_value = 8'h00;
    endcase
  endfunction : reset_value

  function automatic logic vas_locked(input logic [2:0] code);
    vas_locked = (code == `SBS_ADC_VAS_LO) || (code == `SBS_ADC_VAS_HI);
  endfunction : vas_locked

  logic [7:0] vco_reg;
  logic       vas_on;
  logic       standby_bit;
  logic       take;
  logic       wr_ok;

  assign vco_reg = st_r.regs[`SBS_REG_VCO];
  assign vas_on  = vco_reg[`SBS_VCO_VAS];
  assign standby_bit    = st_r.regs[`SBS_REG_CTRL][`SBS_CTRL_STANDBY_BIT];
  assign take    = link.req && !st_r.ack;
  assign wr_ok   = take && link.we && (link.addr <= `SBS_REG_TEST);

  always_comb
  begin
    st_nxt     = st_r;
    st_nxt.ack = take;

    // pin synchronisers, a change counts once stages two and three agree
    st_nxt.code_s1 = tune_code_pin;
    st_nxt.code_s2 = st_r.code_s1;
    st_nxt.code_s3 = st_r.code_s2;
    if (st_r.code_s2 == st_r.code_s3)
      st_nxt.code_f = st_r.code_s3;
    st_nxt.lock_s1 = pll_lock_pin;
    st_nxt.lock_s2 = st_r.lock_s1;
    st_nxt.lock_s3 = st_r.lock_s2;
    if (st_r.lock_s2 == st_r.lock_s3)
      st_nxt.lock_f = st_r.lock_s3;

    // register reads
    if (take && !link.we)
    begin
      case (link.addr)
        `SBS_REG_STAT1:
        begin
          st_nxt.rdata = {st_r.por, st_r.as_ok, st_r.as_st == AS_IDLE,
                          st_r.lock_f & st_r.regs[`SBS_REG_TEST][`SBS_TEST_FAST],
                          4'h0};
          st_nxt.stat_rd = 1'b1;
        end
        `SBS_REG_STAT2: st_nxt.rdata = {st_r.band, st_r.adc};
        default:
          if (link.addr <= `SBS_REG_TEST)
            st_nxt.rdata = st_r.regs[link.addr];
          else
            st_nxt.rdata = 8'h00;
      endcase
    end

    // power-on flag falls at the stop that ends a status read
    if (link.stop)
    begin
      if (st_r.stat_rd)
        st_nxt.por = 1'b0;
      st_nxt.stat_rd = 1'b0;
    end

    // register writes, retained through standby
    if (wr_ok)
    begin
      st_nxt.regs[link.addr] = link.wdata;
      if (link.addr == `SBS_REG_TEST)
        st_nxt.regs[link.addr][`SBS_TEST_RSVD] = 1'b0;
    end

    // tune adc latch: enable must already be set when the latch bit is written
    if (wr_ok && link.addr == `SBS_REG_VCO && link.wdata[`SBS_VCO_ADL]
        && vco_reg[`SBS_VCO_ADE])
      st_nxt.adc = st_r.code_f;

    // band autoselect
    case (st_r.as_st)
      AS_IDLE:
      begin
        if (!vas_on)
        begin
          st_nxt.band  = vco_reg[`SBS_BAND_FLD];
          st_nxt.as_ok = 1'b0;
        end
        if (wr_ok && link.addr == `SBS_REG_FRAC_LSB && vas_on && !standby_bit)
        begin
          st_nxt.as_st = AS_SETTLE;
          st_nxt.band  = (vco_reg[`SBS_BAND_FLD] > `SBS_LAST_BAND) ? 5'h00
                       : vco_reg[`SBS_BAND_FLD];
          st_nxt.tries = 5'h00;
          st_nxt.cnt   = 16'(SETTLE_CYC);
          st_nxt.as_ok = 1'b0;
        end
      end
      AS_SETTLE:
      begin
        st_nxt.cnt = st_r.cnt - 16'h0001;
        if (st_r.cnt == 16'h0001)
          st_nxt.as_st = AS_CHECK;
      end
      AS_CHECK:
      begin
        if (vas_locked(st_r.code_f))
        begin
          st_nxt.as_st = AS_IDLE;
          st_nxt.as_ok = 1'b1;
          st_nxt.adc   = st_r.code_f;
        end
        else if (st_r.tries == 5'(`SBS_NUM_BANDS - 1))
        begin
          st_nxt.as_st = AS_IDLE;
          st_nxt.as_ok = 1'b0;
        end
        else
        begin
          st_nxt.as_st = AS_SETTLE;
          st_nxt.tries = st_r.tries + 5'h01;
          st_nxt.band  = (st_r.band == `SBS_LAST_BAND) ? 5'h00 : st_r.band + 5'h01;
          st_nxt.cnt   = 16'(SETTLE_CYC);
        end
      end
      default: st_nxt.as_st = AS_IDLE;
    endcase

    // standby leaves only the bus and crystal paths alive
    st_nxt.synth_en = !st_nxt.regs[`SBS_REG_CTRL][`SBS_CTRL_STANDBY_BIT];
    st_nxt.rf_en    = !st_nxt.regs[`SBS_REG_CTRL][`SBS_CTRL_STANDBY_BIT];
    if (st_nxt.regs[`SBS_REG_CTRL][`SBS_CTRL_STANDBY_BIT] && st_r.as_st != AS_IDLE)
      st_nxt.as_st = AS_IDLE;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_r          <= '0;
      for (int i = 0; i < `SBS_NUM_RW; i++)
        st_r.regs[i] <= reset_value(i);
      st_r.por      <= 1'b1;
      st_r.as_st    <= AS_IDLE;
      st_r.band     <= `SBS_RST_BAND;
      st_r.synth_en <= 1'b1;
      st_r.rf_en    <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign link.ack       = st_r.ack;
  assign link.rdata     = st_r.rdata;
  assign band_sel       = st_r.band;
  assign synth_en       = st_r.synth_en;
  assign rf_path_en     = st_r.rf_en;
  assign pump_test_mode = st_r.regs[`SBS_REG_TEST][`SBS_PUMP_FLD];
  assign fast_lock      = st_r.regs[`SBS_REG_TEST][`SBS_TEST_FAST];
  assign ref_out_select = st_r.regs[`SBS_REG_TEST][`SBS_REFSEL_FLD];
endmodule : sbs_device

// File: design/sbs_host.sv
/*
  host end: axi4-lite slave with a command and a status word, driving the register link.
  assumes software waits for busy to fall before the next command.
*/
`timescale 1ns/1ps
`include "sbs_consts.svh"
module sbs_host
#(
  parameter int PWRUP_CYC = `SBS_PWRUP_CYC
)
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite slave
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // register link
  sbs_link_if.host         link
);
  import sbs_pkg::*;

  if (PWRUP_CYC < 1 || PWRUP_CYC > 65535)
  begin : g_bad_pwrup
    $error("power-up count out of range");
  end

  typedef struct packed {
    logic        aw_have;
    logic [3:0]  awaddr;
    logic        w_have;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [15:0] pwr_cnt;
    logic        powered;
    sbs_link_e   lk_st;
    logic        req;
    logic        we;
    logic [3:0]  addr;
    logic [7:0]  lwdata;
    logic        stop;
    logic [7:0]  last_rd;
    logic [4:0]  dirty;
    logic        tune_bad;
  } sbs_host_s;

  sbs_host_s st_r;
  sbs_host_s st_nxt;

  logic       cmd_ok;
  logic [3:0] c_addr;
  logic [7:0] c_data;

  assign c_addr = st_r.wdata[`SBS_CMD_ADDR_FLD];
  assign c_data = st_r.wdata[`SBS_CMD_DATA_FLD];
  assign cmd_ok = st_r.powered && st_r.lk_st == LK_IDLE && st_r.wstrb != 4'h0;

  always_comb
  begin
    st_nxt = st_r;
    if (st_r.pwr_cnt != 16'h0000)
      st_nxt.pwr_cnt = st_r.pwr_cnt - 16'h0001;
    else
      st_nxt.powered = 1'b1;

    if (s_axi_awvalid && st_r.awready)
    begin
      st_nxt.aw_have = 1'b1;
      st_nxt.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_r.wready)
    begin
      st_nxt.w_have = 1'b1;
      st_nxt.wdata  = s_axi_wdata;
      st_nxt.wstrb  = s_axi_wstrb;
    end
    if (st_r.bvalid && s_axi_bready)
      st_nxt.bvalid = 1'b0;

    // both halves in hand: act on the command word
    if (st_r.aw_have && st_r.w_have && !st_r.bvalid)
    begin
      st_nxt.aw_have = 1'b0;
      st_nxt.w_have  = 1'b0;
      st_nxt.bvalid  = 1'b1;
      st_nxt.bresp   = `SBS_RESP_SLVERR;
      if (st_r.awaddr == `SBS_AXI_CMD && cmd_ok)
      begin
        st_nxt.bresp  = `SBS_RESP_OKAY;
        st_nxt.lk_st  = LK_REQ;
        st_nxt.req    = 1'b1;
        st_nxt.we     = !st_r.wdata[`SBS_CMD_RD];
        st_nxt.addr   = c_addr;
        st_nxt.lwdata = c_data;
        if (c_addr == `SBS_REG_TEST)
        begin
          st_nxt.lwdata[`SBS_TEST_FAST] = 1'b1;
          st_nxt.lwdata[`SBS_REFSEL_FLD] = 3'h0;
        end
        if (c_addr == `SBS_REG_INT_HI)
          st_nxt.lwdata[`SBS_INT_HI_TOP] = 1'b0;
        if (!st_r.wdata[`SBS_CMD_RD])
        begin
          case (c_addr)
            `SBS_REG_INT_HI:   st_nxt.dirty[0] = 1'b1;
            `SBS_REG_INT_LO:   st_nxt.dirty[1] = 1'b1;
            `SBS_REG_FRAC_MSB: st_nxt.dirty[2] = 1'b1;
            `SBS_REG_REFDIV,
            `SBS_REG_PLL:      st_nxt.dirty[3] = 1'b1;
            `SBS_REG_FRAC_LSB:
            begin
              st_nxt.tune_bad = (st_r.dirty[2:0] != 3'h7);
              st_nxt.dirty    = 5'h00;
            end
            default:           st_nxt.dirty = st_r.dirty;
          endcase
        end
      end
    end

    // link sequencing
    case (st_r.lk_st)
      LK_REQ:
        if (link.ack)
        begin
          st_nxt.req   = 1'b0;
          st_nxt.stop  = 1'b1;
          st_nxt.lk_st = LK_STOP;
          if (!st_r.we)
            st_nxt.last_rd = link.rdata;
        end
      LK_STOP:
      begin
        st_nxt.stop  = 1'b0;
        st_nxt.lk_st = LK_IDLE;
      end
      default: st_nxt.lk_st = st_nxt.lk_st;
    endcase

    if (st_r.rvalid && s_axi_rready)
      st_nxt.rvalid = 1'b0;
    if (s_axi_arvalid && st_r.arready)
    begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp  = `SBS_RESP_OKAY;
      case (s_axi_araddr)
        `SBS_AXI_CMD:  st_nxt.rdata = {20'h00000, st_r.addr, st_r.lwdata};
        `SBS_AXI_STAT: st_nxt.rdata = {16'h0000, st_r.last_rd, 4'h0, st_r.dirty != 5'h00,
                                       st_r.tune_bad, st_r.powered, st_r.lk_st != LK_IDLE};
        default:
        begin
          st_nxt.rdata = 32'h00000000;
          st_nxt.rresp = `SBS_RESP_SLVERR;
        end
      endcase
    end

    st_nxt.awready = !st_nxt.aw_have && !st_nxt.bvalid;
    st_nxt.wready  = !st_nxt.w_have && !st_nxt.bvalid;
    st_nxt.arready = !st_nxt.rvalid;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_r         <= '0;
      st_r.pwr_cnt <= 16'(PWRUP_CYC);
      st_r.lk_st   <= LK_IDLE;
      st_r.awready <= 1'b1;
      st_r.wready  <= 1'b1;
      st_r.arready <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign s_axi_awready = st_r.awready;
  assign s_axi_wready  = st_r.wready;
  assign s_axi_bvalid  = st_r.bvalid;
  assign s_axi_bresp   = st_r.bresp;
  assign s_axi_arready = st_r.arready;
  assign s_axi_rvalid  = st_r.rvalid;
  assign s_axi_rdata   = st_r.rdata;
  assign s_axi_rresp   = st_r.rresp;
  assign link.req      = st_r.req;
  assign link.we       = st_r.we;
  assign link.addr     = st_r.addr;
  assign link.wdata    = st_r.lwdata;
  assign link.stop     = st_r.stop;
endmodule : sbs_host

// File: sim/sbs_link_monitor.sv
/*
  link monitor: assertions on the register link between host end and device end.
  assumes one aclk domain with synchronous active-low aresetn.
*/
`timescale 1ns/1ps
module sbs_link_monitor
(
  // clock and reset
  input wire logic               aclk,
  input wire logic               aresetn,
  // link
  input wire logic               req,
  input wire logic               we,
  input wire sbs_pkg::sbs_addr_t addr,
  input wire sbs_pkg::sbs_byte_t wdata,
  input wire logic               stop,
  input wire logic               ack,
  input wire sbs_pkg::sbs_byte_t rdata
);
  import sbs_pkg::*;
  logic last_st1_r;
  logic por_gone_r;
  wire  st1_ack = ack && !we && addr == 4'hC;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // status read closed by stop clears the power-on flag
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      last_st1_r <= 1'b0;
    else if (ack)
      last_st1_r <= st1_ack;
    if (!aresetn)
      por_gone_r <= 1'b0;
    else if (stop && last_st1_r)
      por_gone_r <= 1'b1;
  end
  sequence release_s;
    !req && stop ##1 !stop;
  endsequence
  sequence held_s;
    req && $stable(we) && $stable(addr) && $stable(wdata);
  endsequence
  ack_pulse_a: assert property (ack |=> !ack)
    else $error("ack held over one cycle");
  ack_latency_a: assert property (req && !ack |=> ack)
    else $error("request not answered next cycle");
  req_hold_a: assert property (req && !ack |=> held_s)
    else $error("request dropped before ack");
  host_release_a: assert property (ack |=> release_s)
    else $error("transfer not closed by stop");
  rdata_hold_a: assert property ($changed(rdata) |-> ack)
    else $error("read data moved without ack");
  test_fixed_a: assert property (req && we && addr == 4'hB |-> wdata[3:0] == 4'h8)
    else $error("test write lacks fast lock or normal ref out");
  int_top_a: assert property (req && we && addr == 4'h0 |-> !wdata[7])
    else $error("integer high byte bit 7 set");
  test_rsvd_a: assert property (ack && !we && addr == 4'hB |-> rdata[4:0] == 5'h08)
    else $error("test register fixed bits wrong");
  st1_rsvd_a: assert property (st1_ack |-> rdata[3:0] == 4'h0)
    else $error("status reserved bits not zero");
  por_set_a: assert property (st1_ack && !por_gone_r |-> rdata[7])
    else $error("power-on flag missing");
  por_clear_a: assert property (st1_ack && por_gone_r |-> !rdata[7])
    else $error("power-on flag not cleared");
endmodule : sbs_link_monitor

// File: sim/tb_top.sv
/*
  testbench: axi4-lite stimulus into the host end, host and device joined by the link.
  assumes the link timing of both ends and a 100 MHz aclk.
*/
`timescale 1ns/1ps
`include "sbs_consts.svh"
`define CHK(nm, got, exp) begin compares++; if ((got) !== (exp)) begin err_count++; \
  $display("BAD %s exp=%0h got=%0h", nm, exp, got); end end
module tb_top;
  import sbs_pkg::*;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [3:0]  awaddr = 4'h0;
  logic        awvalid = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  strb = 4'hF;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic [3:0]  araddr = 4'h0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        lock_pin = 1'b1;
  logic [2:0]  tcode = 3'h0;
  logic [2:0]  tsel = 3'h0;
  logic        as_on = 1'b0;
  logic [4:0]  tgt = 5'h0;
  wire         awready, wready, bvalid, arready, rvalid, synth_en, rf_en, fast;
  wire [1:0]   bresp, rresp;
  wire [31:0]  rdata;
  wire [4:0]   band;
  wire [2:0]   ptest, rsel;
  int          err_count = 0;
  int          compares = 0;
  int          seed = 32'hA30F;
  sbs_addr_t   div_a [4] = '{4'h0, 4'h1, 4'h3, 4'h4};
  sbs_link_if link();
  sbs_device #(.SETTLE_CYC(8)) u_sbs_device
  (
    .aclk(aclk), .aresetn(aresetn), .link(link), .pll_lock_pin(lock_pin),
    .tune_code_pin(tcode), .band_sel(band), .synth_en(synth_en), .rf_path_en(rf_en),
    .pump_test_mode(ptest), .fast_lock(fast), .ref_out_select(rsel)
  );
  sbs_host #(.PWRUP_CYC(20)) u_sbs_host
  (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .link(link)
  );
  sbs_link_monitor u_sbs_link_monitor
  (
    .aclk(aclk), .aresetn(aresetn), .req(link.req), .we(link.we), .addr(link.addr),
    .wdata(link.wdata), .stop(link.stop), .ack(link.ack), .rdata(link.rdata)
  );
  initial forever #5 aclk = ~aclk;
  // during a search the tune code answers per band
  always @(posedge aclk)
    tcode <= as_on ? ((band == tgt) ? 3'b101 : 3'b001) : tsel;
  function automatic sbs_byte_t exp_test(input sbs_byte_t d);
    return (d & 8'hE0) | 8'h08;
  endfunction : exp_test
  function automatic logic [4:0] band_after(input logic [4:0] b, input int k);
    return 5'((int'(b) + k) % 24);
  endfunction : band_after
  task automatic finish_test();
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  task automatic hang();
    err_count++;
    $display("BAD wait exp=done got=timeout");
    finish_test();
  endtask : hang
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (!bvalid && n < 100);
    r = bresp;
    bready <= 1'b0;
    if (n >= 100) hang();
    @(posedge aclk);
  endtask : axi_wr
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end
    while (!rvalid && n < 100);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n >= 100) hang();
    @(posedge aclk);
  endtask : axi_rd
  task automatic lk(input logic rd, input sbs_addr_t a, input sbs_byte_t d,
                    output sbs_byte_t q);
    logic [31:0] v;
    logic [1:0]  r;
    int          n;
    axi_wr(`SBS_AXI_CMD, {15'h0, rd, 4'h0, a, d}, r);
    `CHK("cmd_resp", r, `SBS_RESP_OKAY)
    n = 0;
    do
    begin
      axi_rd(`SBS_AXI_STAT, v, r);
      n++;
    end
    while (v[0] !== 1'b0 && n < 50);
    if (v[0] !== 1'b0) hang();
    q = v[15:8];
  endtask : lk
  task automatic poll_done(output sbs_byte_t q);
    int n;
    n = 0;
    do
    begin
      lk(1'b1, 4'hC, 8'h00, q);
      n++;
    end
    while (q[5] !== 1'b1 && n < 40);
    if (q[5] !== 1'b1) hang();
  endtask : poll_done
  initial
  begin
    logic [31:0] v;
    logic [1:0]  r;
    sbs_byte_t   q;
    sbs_byte_t   d;
    logic [4:0]  b;
    logic [4:0]  st;
    int          n;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    axi_wr(`SBS_AXI_CMD, 32'h0001_0C00, r);
    `CHK("early_cmd", r, `SBS_RESP_SLVERR)
    axi_rd(4'h8, v, r);
    `CHK("unmapped_rd", {r, v}, {`SBS_RESP_SLVERR, 32'h0})
    axi_wr(`SBS_AXI_STAT, 32'h0, r);
    `CHK("stat_wr", r, `SBS_RESP_SLVERR)
    n = 0;
    do
    begin
      axi_rd(`SBS_AXI_STAT, v, r);
      n++;
    end
    while (v[1] !== 1'b1 && n < 30);
    if (v[1] !== 1'b1) hang();
    strb <= 4'h0;
    axi_wr(`SBS_AXI_CMD, 32'h0001_0C00, r);
    `CHK("nostrb_cmd", r, `SBS_RESP_SLVERR)
    strb <= 4'hF;
    lk(1'b1, 4'hC, 8'h00, q);
    `CHK("stat1_por", q, 8'hB0)
    lk(1'b1, 4'hC, 8'h00, q);
    `CHK("stat1_read", q, 8'h30)
    lk(1'b1, 4'hB, 8'h00, q);
    `CHK("test_rst", q, 8'h08)
    repeat (4)
    begin
      d = 8'($random(seed));
      lk(1'b0, 4'hB, d, q);
      lk(1'b1, 4'hB, 8'h00, q);
      `CHK("test_rd", q, exp_test(d))
      `CHK("test_pins", {ptest, fast, rsel}, {d[7:5], 4'h8})
    end
    lk(1'b0, 4'hB, 8'h08, q);
    lock_pin <= 1'b0;
    repeat (6) @(posedge aclk);
    lk(1'b1, 4'hC, 8'h00, q);
    `CHK("lock_low", q[4], 1'b0)
    lock_pin <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      d = 8'($random(seed));
      b = (i == 7) ? 5'h17 : d[4:0] % 5'd24;
      lk(1'b0, 4'h7, {b, 3'b001}, q);
      tsel <= 3'(i);
      repeat (6) @(posedge aclk);
      lk(1'b0, 4'h7, {b, 3'b011}, q);
      lk(1'b1, 4'hD, 8'h00, q);
      `CHK("stat2", q, {b, 3'(i)})
      `CHK("band_pin", band, b)
    end
    lk(1'b0, 4'hD, 8'hFF, q);
    lk(1'b0, 4'hC, 8'hFF, q);
    lk(1'b1, 4'hD, 8'h00, q);
    `CHK("stat2_ro", q, 8'hBF)
    lk(1'b1, 4'hC, 8'h00, q);
    `CHK("stat1_ro", {q[7], q[3:0]}, 5'h00)
    for (int k = 0; k < 2; k++)
    begin
      d = 8'($random(seed));
      st = (k == 1) ? 5'h14 : d[4:0] % 5'd24;
      tgt <= band_after(st, 6);
      as_on <= 1'b1;
      lk(1'b0, 4'h7, {st, 3'b100}, q);
      foreach (div_a[j])
        lk(1'b0, div_a[j], 8'($random(seed)), q);
      lk(1'b1, 4'hC, 8'h00, q);
      `CHK("as_busy", q[5], 1'b0)
      poll_done(q);
      `CHK("as_ok", q[6:5], 2'b11)
      lk(1'b1, 4'hD, 8'h00, q);
      `CHK("as_band", q, {band_after(st, 6), 3'b101})
      axi_rd(`SBS_AXI_STAT, v, r);
      `CHK("div_flags", v[3:2], 2'b00)
    end
    as_on <= 1'b0;
    @(posedge aclk);
    tsel <= 3'b001;
    lk(1'b0, 4'h4, 8'h00, q);
    poll_done(q);
    `CHK("as_fail", q[6:5], 2'b01)
    axi_rd(`SBS_AXI_STAT, v, r);
    `CHK("tune_flag", v[3:2], 2'b01)
    d = 8'($random(seed));
    lk(1'b0, 4'h5, d, q);
    axi_rd(`SBS_AXI_STAT, v, r);
    `CHK("div_pend", v[3:2], 2'b11)
    axi_rd(`SBS_AXI_CMD, v, r);
    `CHK("cmd_rb", v, {20'h0, 4'h5, d})
    lk(1'b0, 4'h9, 8'h80, q);
    `CHK("standby_bit_off", {synth_en, rf_en}, 2'b00)
    lk(1'b0, 4'h9, 8'h00, q);
    `CHK("standby_bit_on", {synth_en, rf_en}, 2'b11)
    lk(1'b1, 4'h5, 8'h00, q);
    `CHK("standby_bit_keep", q, d)
    finish_test();
  end
endmodule : tb_top
